// ===== cit_defines.svh
// Timing constants and opcode field values for the instruction timing decoder
`ifndef CIT_DEFINES_SVH
`define CIT_DEFINES_SVH

`define CIT_CLK_MHZ          20
`define CIT_MAX_CLK_MHZ      25
`define CIT_INSTR_COUNT      109
`define CIT_MAX_CLOCKS       4'h8
`define CIT_BRANCH_SAVE      4'h1
`define CIT_INDIR_CLOCKS     4'h2
`define CIT_XFER_CLOCKS      4'h3
`define CIT_MUL_CLOCKS       4'h4

`define CIT_OP_EXTERNAL_DATA_MOVE_LO       8'hE0
`define CIT_OP_CODE_MEMORY_READ_DATA_POINTER     8'h93
`define CIT_OP_CODE_MEMORY_READ_PC       8'h83
`define CIT_OP_LOAD_DP       8'h90
`define CIT_OP_MOV_DD        8'h85
`define CIT_OP_MOV_DI        8'h75
`define CIT_OP_XRL_DI        8'h63
`define CIT_OP_PUSH          8'hC0
`define CIT_OP_POP           8'hD0
`define CIT_OP_DIV           8'h84
`define CIT_OP_MUL           8'hA4

`endif

// ===== cit_pkg.sv
// Types shared by the instruction timing decoder
package cit_pkg;
	typedef enum logic [1:0] {
		CIT_IDLE  = 2'b00,
		CIT_FETCH = 2'b01,
		CIT_EXEC  = 2'b11,
		CIT_DONE  = 2'b10
	} cit_state_t;

	typedef enum logic [2:0] {
		CIT_CLS_ACC    = 3'h0,
		CIT_CLS_MOVE   = 3'h1,
		CIT_CLS_INDIR  = 3'h2,
		CIT_CLS_EXT    = 3'h3,
		CIT_CLS_BRANCH = 3'h4,
		CIT_CLS_BIT    = 3'h5,
		CIT_CLS_OTHER  = 3'h6
	} cit_class_t;
endpackage : cit_pkg

// ===== cit_len_table.sv
// Opcode to byte length, base clocks, taken-branch clocks and class
`include "cit_defines.svh"
module cit_len_table (
	// Opcode
	input  wire logic [7:0]        opcode,
	// Decoded timing
	output logic      [1:0]        bytes,
	output logic      [3:0]        clocks,
	output logic      [3:0]        taken_clocks,
	output logic                   is_branch,
	output cit_pkg::cit_class_t    op_class
);
	function automatic logic [1:0] len_of(input logic [7:0] op);
		logic [3:0] lo;
		logic [3:0] hi;
		lo = op[3:0];
		hi = op[7:4];
		len_of = 2'h1;
		if (op == `CIT_OP_LOAD_DP || op == `CIT_OP_MOV_DD || op == `CIT_OP_MOV_DI || op == `CIT_OP_XRL_DI)
			len_of = 2'h3;
		else if (lo[3:0] == 4'h1)
			len_of = 2'h2;
		else if (lo == 4'h2 && hi <= 4'h1)
			len_of = 2'h3;
		else if (lo == 4'h0 && (hi == 4'h1 || hi == 4'h2 || hi == 4'h3))
			len_of = 2'h3;
		else if (lo == 4'h0 && (hi == 4'h4 || hi == 4'h5 || hi == 4'h6 || hi == 4'h7 || hi == 4'h8))
			len_of = 2'h2;
		else if (lo == 4'h0 && (hi == 4'hC || hi == 4'hD))
			len_of = 2'h2;
		else if ((lo == 4'h2 || lo == 4'h3) && hi >= 4'h4 && hi <= 4'h6)
			len_of = (lo == 4'h3) ? 2'h3 : 2'h2;
		else if (lo == 4'h2 && (hi == 4'h7 || hi == 4'h8 || hi == 4'h9 || hi == 4'hA
			|| hi == 4'hB || hi == 4'hC || hi == 4'hD))
			len_of = 2'h2;
		else if (lo == 4'h0 && (hi == 4'h9 || hi == 4'hA || hi == 4'hB))
			len_of = 2'h2;
		// Divide sits among the immediate forms but carries no operand byte
		else if ((lo == 4'h4 || lo == 4'h5) && hi >= 4'h2 && hi <= 4'h9 && op != `CIT_OP_DIV)
			len_of = 2'h2;
		else if (lo == 4'h5 && (hi == 4'h0 || hi == 4'h1 || hi == 4'hC || hi == 4'hE || hi == 4'hF))
			len_of = 2'h2;
		else if (lo == 4'h5 && (hi == 4'hB || hi == 4'hD))
			len_of = 2'h3;
		else if (lo == 4'h4 && hi == 4'hB)
			len_of = 2'h3;
		else if ((lo == 4'h6 || lo == 4'h7) && (hi == 4'h7 || hi == 4'h8 || hi == 4'hA))
			len_of = 2'h2;
		else if ((lo == 4'h6 || lo == 4'h7) && hi == 4'hB)
			len_of = 2'h3;
		else if (lo >= 4'h8 && (hi == 4'h7 || hi == 4'h8 || hi == 4'hA || hi == 4'hD))
			len_of = 2'h2;
		else if (lo >= 4'h8 && hi == 4'hB)
			len_of = 2'h3;
		else if (lo >= 4'h6 && (hi == 4'h2 || hi == 4'h3 || hi == 4'h4 || hi == 4'h5 || hi == 4'h6 || hi == 4'h9))
			len_of = 2'h1;
	endfunction : len_of

	function automatic logic is_cond_branch(input logic [7:0] op);
		is_cond_branch = (op[3:0] == 4'h0 && op[7:4] >= 4'h1 && op[7:4] <= 4'h7 && op[7:4] != 4'h2 + 4'h0 - 4'h0
			&& 1'b1) || op == 8'h20 || (op[7:4] == 4'hB && op[3:0] >= 4'h4) || (op[7:4] == 4'hD
			&& (op[3:0] == 4'h5 || op[3:0] >= 4'h8));
	endfunction : is_cond_branch

	always_comb begin
		logic [7:0] op;
		op           = opcode;
		bytes        = len_of(op);
		clocks       = {2'h0, bytes};
		is_branch    = is_cond_branch(op);
		op_class     = cit_pkg::CIT_CLS_OTHER;
		if (op[7:4] >= 4'hC && op[3:0] == 4'h4 || op == 8'h03 || op == 8'h13 || op == 8'h23 || op == 8'h33)
			op_class = cit_pkg::CIT_CLS_ACC;
		if (op >= 8'hC3 && op <= 8'hD3 && op[3:0] == 4'h3 || op == 8'hB3 || op == 8'hC2 || op == 8'hD2 || op == 8'hB2)
			op_class = cit_pkg::CIT_CLS_BIT;
		if (op[3:0] == 4'h6 || op[3:0] == 4'h7) begin
			op_class = cit_pkg::CIT_CLS_INDIR;
			if (bytes == 2'h1)
				clocks = `CIT_INDIR_CLOCKS;
		end
		if (op[7:4] >= 4'hE && (op[3:0] == 4'h0 || op[3:0] == 4'h2 || op[3:0] == 4'h3)) begin
			op_class = cit_pkg::CIT_CLS_EXT;
			clocks   = `CIT_XFER_CLOCKS;
		end
		if (op == `CIT_OP_CODE_MEMORY_READ_DATA_POINTER || op == `CIT_OP_CODE_MEMORY_READ_PC) begin
			op_class = cit_pkg::CIT_CLS_EXT;
			clocks   = `CIT_XFER_CLOCKS;
		end
		if (op == `CIT_OP_PUSH || op == `CIT_OP_POP || op[3:0] >= 4'h8 && op[7:4] >= 4'hE)
			op_class = cit_pkg::CIT_CLS_MOVE;
		if (op == `CIT_OP_DIV)
			clocks = `CIT_MAX_CLOCKS;
		if (op == `CIT_OP_MUL)
			clocks = `CIT_MUL_CLOCKS;
		taken_clocks = clocks;
		if (is_branch) begin
			op_class     = cit_pkg::CIT_CLS_BRANCH;
			taken_clocks = clocks + `CIT_BRANCH_SAVE;
		end
	end
endmodule : cit_len_table

// ===== cit_core_timing.sv
// Instruction timing sequencer: counts each instruction's clocks
`include "cit_defines.svh"
module cit_core_timing (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                nrst,
	// Instruction issue
	input  wire logic                issue_valid,
	input  wire logic [7:0]          opcode,
	input  wire logic                branch_taken,
	output logic                     issue_ready,
	// Timing results
	output logic      [1:0]          instr_bytes,
	output logic      [3:0]          instr_clocks,
	output cit_pkg::cit_class_t      instr_class,
	output logic                     instr_done,
	output cit_pkg::cit_state_t      state
);
	logic                rst_meta;
	logic                rst_sync;
	logic [1:0]          dec_bytes;
	logic [3:0]          dec_clocks;
	logic [3:0]          dec_taken;
	logic                dec_branch;
	cit_pkg::cit_class_t dec_class;
	logic [3:0]          remain;
	logic [3:0]          next_remain;
	cit_pkg::cit_state_t next_state;
	logic [1:0]          next_bytes;
	logic [3:0]          next_clocks;
	cit_pkg::cit_class_t next_class;
	logic                next_done;

	// Reset released through two flops so all logic leaves reset on one edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	cit_len_table u_table (
		.opcode       (opcode),
		.bytes        (dec_bytes),
		.clocks       (dec_clocks),
		.taken_clocks (dec_taken),
		.is_branch    (dec_branch),
		.op_class     (dec_class)
	);

	// New instruction accepted on the clock its predecessor ends: one per clock peak
	assign issue_ready = (remain <= 4'h1);

	always_comb begin
		next_remain = remain;
		next_state  = state;
		next_bytes  = instr_bytes;
		next_clocks = instr_clocks;
		next_class  = instr_class;
		next_done   = 1'b0;
		if (remain != 4'h0)
			next_remain = remain - 4'h1;
		if (remain == 4'h1) begin
			next_done  = 1'b1;
		end
		if (issue_valid && issue_ready) begin
			// Branch outcome must be valid with the opcode; it picks the clock count, not the byte length
			next_clocks = (dec_branch && branch_taken) ? dec_taken : dec_clocks;
			next_remain = next_clocks;
			next_bytes  = dec_bytes;
			next_class  = dec_class;
			next_state  = (next_clocks == 4'h1) ? cit_pkg::CIT_FETCH : cit_pkg::CIT_EXEC;
		end else begin
			case (state)
				cit_pkg::CIT_IDLE:  next_state = cit_pkg::CIT_IDLE;
				cit_pkg::CIT_FETCH: next_state = cit_pkg::CIT_DONE;
				cit_pkg::CIT_EXEC:  next_state = (remain == 4'h1) ? cit_pkg::CIT_DONE : cit_pkg::CIT_EXEC;
				cit_pkg::CIT_DONE:  next_state = cit_pkg::CIT_IDLE;
				default:            next_state = cit_pkg::CIT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			remain       <= 4'h0;
			state        <= cit_pkg::CIT_IDLE;
			instr_bytes  <= 2'h0;
			instr_clocks <= 4'h0;
			instr_class  <= cit_pkg::CIT_CLS_OTHER;
			instr_done   <= 1'b0;
		end else begin
			remain       <= next_remain;
			state        <= next_state;
			instr_bytes  <= next_bytes;
			instr_clocks <= next_clocks;
			instr_class  <= next_class;
			instr_done   <= next_done;
		end
	end
endmodule : cit_core_timing

// ===== cit_core_timing_chk.sv
// Port-level checker for the instruction timing sequencer
module cit_core_timing_chk (
	// Clock and reset
	input wire logic       clock,
	input wire logic       nrst,
	// Issue side
	input wire logic       issue_valid,
	input wire logic [7:0] opcode,
	input wire logic       branch_taken,
	input wire logic       issue_ready,
	// Results
	input wire logic [1:0] instr_bytes,
	input wire logic [3:0] instr_clocks,
	input wire logic       instr_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic take;
	assign take = issue_valid && issue_ready;
	a_done_follows: assert property (take |-> ##[1:10] instr_done) else $error("no done after issue");
	a_acc_one: assert property (take && opcode inside {8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4}
		|=> instr_clocks == 4'h1 && instr_bytes == 2'h1) else $error("accumulator op timing");
	a_reg_move: assert property (take && opcode inside {8'hE8, 8'hF8, 8'hC8}
		|=> instr_clocks == 4'h1 && instr_bytes == 2'h1) else $error("register move timing");
	a_indir_two: assert property (take && opcode inside {8'hE6, 8'hF6, 8'hC6, 8'hD6, 8'hD7}
		|=> instr_clocks == 4'h2 && instr_bytes == 2'h1) else $error("indirect move timing");
	a_ext_three: assert property (take && opcode inside {8'hE0, 8'hF0, 8'hE2, 8'hF2, 8'h93, 8'h83}
		|=> instr_clocks == 4'h3 && instr_bytes == 2'h1) else $error("external or code read timing");
	a_three_byte: assert property (take && opcode inside {8'h90, 8'h85, 8'h75, 8'h63}
		|=> instr_clocks == 4'h3 && instr_bytes == 2'h3) else $error("three byte op timing");
	a_branch_save: assert property (take && opcode == 8'h40
		|=> instr_clocks == 4'h2 + {3'h0, $past(branch_taken)}) else $error("branch timing");
	a_div_busy: assert property (take && opcode == 8'h84 |=> !issue_ready [*6]) else $error("long op refused");
	a_peak_rate: assert property (take && opcode == 8'hE4 |=> issue_ready) else $error("one clock op stalls");
	a_stand_still: assert property (!issue_ready |=> $stable(instr_clocks) && $stable(instr_bytes))
		else $error("results moved while busy");
endmodule : cit_core_timing_chk

bind cit_core_timing cit_core_timing_chk cit_core_timing_chk_inst (.clock(clock), .nrst(nrst),
	.issue_valid(issue_valid), .opcode(opcode), .branch_taken(branch_taken), .issue_ready(issue_ready),
	.instr_bytes(instr_bytes), .instr_clocks(instr_clocks), .instr_done(instr_done));

// ===== cit_core_timing_test.sv
// Self-checking bench for the instruction timing sequencer
module cit_core_timing_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clock, nrst, issue_valid, branch_taken, issue_ready, instr_done, have;
	logic [7:0]          opcode, pb, pc, po;
	logic [1:0]          instr_bytes;
	logic [3:0]          instr_clocks;
	cit_pkg::cit_class_t instr_class;
	cit_pkg::cit_state_t state;
	int                  fails, n_tests, n_take, n_done, seed, r, j;
	// Opcode, bytes, clocks, extra clock when taken
	logic [19:0] tbl [$] = '{20'hE4110, 20'hF4110, 20'h23110, 20'h33110, 20'h03110, 20'h13110, 20'hC4110,
		20'hE8110, 20'hF8110, 20'hC8110, 20'hE5220, 20'hA8220, 20'hF5220, 20'h88220, 20'hC5220,
		20'hE6120, 20'hF6120, 20'hC6120, 20'hD6120, 20'hD7120, 20'hE0130, 20'hF0130, 20'hE2130,
		20'hF2130, 20'h93130, 20'h83130, 20'h90330, 20'h85330, 20'h75330, 20'h63330, 20'h74220,
		20'h78220, 20'h76220, 20'hC0220, 20'hD0220, 20'hC3110, 20'hD3110, 20'hB3110, 20'hC2220,
		20'hD2220, 20'hB2220, 20'h40221, 20'h00110, 20'h84180, 20'hA4140};
	cit_core_timing cit_core_timing_inst (.clock(clock), .nrst(nrst), .issue_valid(issue_valid),
		.opcode(opcode), .branch_taken(branch_taken), .issue_ready(issue_ready), .instr_bytes(instr_bytes),
		.instr_clocks(instr_clocks), .instr_class(instr_class), .instr_done(instr_done), .state(state));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// Class groups follow the rule groups, not the decoder's own tests
	function automatic cit_pkg::cit_class_t exp_class(input logic [7:0] op);
		exp_class = cit_pkg::CIT_CLS_OTHER;
		if (op[3:0] == 4'h6 || op[3:0] == 4'h7)
			exp_class = cit_pkg::CIT_CLS_INDIR;
		if (op inside {8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4})
			exp_class = cit_pkg::CIT_CLS_ACC;
		if (op inside {8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2})
			exp_class = cit_pkg::CIT_CLS_BIT;
		if (op inside {8'hE0, 8'hF0, 8'hE2, 8'hF2, 8'h93, 8'h83})
			exp_class = cit_pkg::CIT_CLS_EXT;
		if (op inside {8'hC0, 8'hD0, 8'hE8, 8'hF8})
			exp_class = cit_pkg::CIT_CLS_MOVE;
		if (op == 8'h40)
			exp_class = cit_pkg::CIT_CLS_BRANCH;
	endfunction : exp_class
	task automatic results();
		check("instr_bytes", {6'h0, instr_bytes}, pb);
		check("instr_clocks", {4'h0, instr_clocks}, pc);
		check("instr_class", 8'(instr_class), 8'(exp_class(po)));
		check("state", 8'(state), 8'((pc == 8'h1) ? cit_pkg::CIT_FETCH : cit_pkg::CIT_EXEC));
	endtask : results
	// Valid stays up across back-to-back issues, so the spacing measures the design's own stall
	task automatic issue(input logic [19:0] e, input logic bt);
		int k;
		issue_valid <= 1'b1;
		opcode <= e[19:12];
		branch_taken <= bt;
		k = 1;
		@(negedge clock);
		if (have)
			results();
		while (issue_ready !== 1'b1 && k < 20) begin
			@(negedge clock);
			k++;
		end
		@(posedge clock);
		if (have)
			check("spacing", 8'(k), pc);
		pb = {4'h0, e[11:8]};
		po = e[19:12];
		pc = {4'h0, e[7:4]} + {7'h0, e[0] & bt};
		have = 1'b1;
		n_take++;
	endtask : issue
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(negedge clock)
		if (instr_done === 1'b1)
			n_done++;
	initial begin
		#200us;
		fails++;
		give_verdict();
	end
	initial begin
		seed = 32'h611f1ce5;
		nrst = 1'b0;
		issue_valid = 1'b0;
		opcode = 8'h00;
		branch_taken = 1'b0;
		have = 1'b0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		foreach (tbl[i])
			issue(tbl[i], 1'b0);
		issue(20'h40221, 1'b1);
		issue(20'h40221, 1'b0);
		repeat (80) begin
			r = $random(seed);
			j = $unsigned(r) % tbl.size();
			r = $random(seed);
			issue(tbl[j], r[0]);
		end
		issue_valid <= 1'b0;
		@(negedge clock);
		results();
		repeat (12) @(posedge clock);
		check("done pulses", 8'(n_done), 8'(n_take));
		give_verdict();
	end
endmodule : cit_core_timing_test
